// [hdl/cbr_pkg.sv]
// Package of constants and types for the core basic register block.
package cbr_pkg;
    localparam int CBR_DATA_W = 8;
    localparam int CBR_ADDR_W = 16;
    localparam int CBR_NUM_BANKS = 4;
    localparam int CBR_REGS_PER_BANK = 8;
    localparam int CBR_BANK_AREA = 32;
    localparam int CBR_RAM_DEPTH = 256;
    localparam logic [7:0] CBR_SFR_BASE = 8'h80;
    localparam logic [7:0] CBR_MAIN_ARITH_ADDR = 8'hE0;
    localparam logic [7:0] CBR_SECOND_OP_ADDR = 8'hF0;
    localparam logic [7:0] CBR_STACK_PTR_ADDR = 8'h81;
    localparam logic [7:0] CBR_DP0_LO_ADDR = 8'h82;
    localparam logic [7:0] CBR_DP0_HI_ADDR = 8'h83;
    localparam logic [7:0] CBR_DP1_LO_ADDR = 8'h84;
    localparam logic [7:0] CBR_DP1_HI_ADDR = 8'h85;
    localparam logic [7:0] CBR_DP_SELECT_ADDR = 8'h86;
    localparam logic [7:0] CBR_STATUS_ADDR = 8'hD0;
    localparam int CBR_BANK_SEL_LSB = 3;
    localparam logic [7:0] CBR_STACK_RESET = 8'h07;
    localparam logic [15:0] CBR_PC_RESET = 16'h0000;
    localparam logic [7:0] CBR_BYTE_RESET = 8'h00;

    typedef enum logic [2:0] {
        CBR_OP_NONE = 3'b000,
        CBR_OP_PUSH = 3'b001,
        CBR_OP_POP = 3'b010,
        CBR_OP_MULDIV = 3'b011,
        CBR_OP_ALU = 3'b100
    } cbr_op_type;
endpackage

// [hdl/cbr_core_regs.sv]
// Core working registers: accumulator, operand register, banks, pointers and the program counter.
`timescale 1ns/1ps
module cbr_core_regs
    import cbr_pkg::*;
#(
    parameter int RAM_DEPTH = CBR_RAM_DEPTH
)
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_direct_we,
    input wire logic [7:0] i_direct_addr,
    input wire logic [7:0] i_direct_wdata,
    output logic [7:0] o_direct_rdata,
    input wire logic i_indirect_we,
    input wire logic [7:0] i_indirect_addr,
    input wire logic [7:0] i_indirect_wdata,
    output logic [7:0] o_indirect_rdata,
    input wire logic i_gr_we,
    input wire logic [2:0] i_gr_index,
    input wire logic [7:0] i_gr_wdata,
    output logic [7:0] o_gr_rdata,
    input wire logic i_acc_we,
    input wire logic [7:0] i_acc_wdata,
    output logic [7:0] o_main_arith,
    input wire logic i_muldiv_we,
    input wire logic [7:0] i_muldiv_acc,
    input wire logic [7:0] i_muldiv_second,
    output logic [7:0] o_second_operand,
    input wire logic i_stack_op_valid,
    input wire logic [2:0] i_stack_op,
    input wire logic [7:0] i_push_data,
    output logic [7:0] o_pop_data,
    input wire logic i_instr_done,
    input wire logic [1:0] i_instr_len,
    input wire logic i_pc_load,
    input wire logic [15:0] i_pc_target,
    output logic [15:0] o_program_counter,
    output logic [15:0] o_data_pointer_addr,
    output logic [7:0] o_stack_pointer,
    output logic [1:0] o_bank_select
);
    typedef struct packed {
        logic [7:0] main_arith;
        logic [7:0] second_operand;
        logic [15:0] program_counter;
        logic [15:0] data_pointer_0;
        logic [15:0] data_pointer_1;
        logic data_pointer_select;
        logic [7:0] stack_pointer;
        logic [7:0] status;
        logic [7:0] pop_data;
        logic [7:0] direct_rdata;
        logic [7:0] indirect_rdata;
        logic [7:0] gr_rdata;
    } cbr_state_type;

    cbr_state_type state;
    cbr_state_type next_state;
    logic [7:0] ram [RAM_DEPTH];
    logic rst_meta;
    logic rst_sync;
    logic [1:0] bank;
    logic [7:0] gr_addr;
    logic [7:0] push_addr;
    logic ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;
    cbr_op_type op;

    // Reset is released through two stages so that the state register and the RAM write enable leave reset together.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    function automatic logic [7:0] bank_address(input logic [1:0] b, input logic [2:0] n);
        bank_address = {3'b000, b, n};
    endfunction

    function automatic logic [15:0] pair_write(input logic [15:0] cur, input logic hi,
                                               input logic [7:0] d);
        pair_write = hi ? {d, cur[7:0]} : {cur[15:8], d};
    endfunction

    assign op = cbr_op_type'(i_stack_op);
    assign bank = state.status[CBR_BANK_SEL_LSB +: 2];
    assign gr_addr = bank_address(bank, i_gr_index);
    assign push_addr = state.stack_pointer + 8'h01;

    // One RAM write port; priority push, then bank register, then indirect, then direct.
    always_comb
    begin
        ram_we = 1'b0;
        ram_waddr = 8'h00;
        ram_wdata = 8'h00;
        if (i_stack_op_valid && op == CBR_OP_PUSH)
        begin
            ram_we = 1'b1;
            ram_waddr = push_addr;
            ram_wdata = i_push_data;
        end
        else if (i_gr_we)
        begin
            ram_we = 1'b1;
            ram_waddr = gr_addr;
            ram_wdata = i_gr_wdata;
        end
        else if (i_indirect_we)
        begin
            ram_we = 1'b1;
            ram_waddr = i_indirect_addr;
            ram_wdata = i_indirect_wdata;
        end
        else if (i_direct_we && i_direct_addr < CBR_SFR_BASE)
        begin
            ram_we = 1'b1;
            ram_waddr = i_direct_addr;
            ram_wdata = i_direct_wdata;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_ce && rst_sync && ram_we)
        begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

    always_comb
    begin
        next_state = state;
        next_state.gr_rdata = ram[gr_addr];
        next_state.indirect_rdata = ram[i_indirect_addr];
        if (i_direct_addr < CBR_SFR_BASE)
        begin
            next_state.direct_rdata = ram[i_direct_addr];
        end
        else
        begin
            case (i_direct_addr)
                CBR_MAIN_ARITH_ADDR: next_state.direct_rdata = state.main_arith;
                CBR_SECOND_OP_ADDR: next_state.direct_rdata = state.second_operand;
                CBR_STACK_PTR_ADDR: next_state.direct_rdata = state.stack_pointer;
                CBR_DP0_LO_ADDR: next_state.direct_rdata = state.data_pointer_0[7:0];
                CBR_DP0_HI_ADDR: next_state.direct_rdata = state.data_pointer_0[15:8];
                CBR_DP1_LO_ADDR: next_state.direct_rdata = state.data_pointer_1[7:0];
                CBR_DP1_HI_ADDR: next_state.direct_rdata = state.data_pointer_1[15:8];
                CBR_DP_SELECT_ADDR: next_state.direct_rdata = {7'h00, state.data_pointer_select};
                CBR_STATUS_ADDR: next_state.direct_rdata = state.status;
                default: next_state.direct_rdata = 8'h00;
            endcase
        end
        // Special register writes; the program counter has no address here.
        if (i_direct_we && i_direct_addr >= CBR_SFR_BASE)
        begin
            case (i_direct_addr)
                CBR_MAIN_ARITH_ADDR: next_state.main_arith = i_direct_wdata;
                CBR_SECOND_OP_ADDR: next_state.second_operand = i_direct_wdata;
                CBR_STACK_PTR_ADDR: next_state.stack_pointer = i_direct_wdata;
                CBR_DP0_LO_ADDR, CBR_DP0_HI_ADDR:
                    next_state.data_pointer_0 = pair_write(state.data_pointer_0,
                        i_direct_addr[0], i_direct_wdata);
                CBR_DP1_LO_ADDR, CBR_DP1_HI_ADDR:
                    next_state.data_pointer_1 = pair_write(state.data_pointer_1,
                        i_direct_addr[0], i_direct_wdata);
                CBR_DP_SELECT_ADDR: next_state.data_pointer_select = i_direct_wdata[0];
                CBR_STATUS_ADDR: next_state.status = i_direct_wdata;
                default: next_state.status = state.status;
            endcase
        end
        if (i_acc_we)
        begin
            next_state.main_arith = i_acc_wdata;
        end
        if (i_muldiv_we)
        begin
            next_state.main_arith = i_muldiv_acc;
            next_state.second_operand = i_muldiv_second;
        end
        // Calls, returns and interrupt entry all decompose into byte pushes and pops.
        if (i_stack_op_valid)
        begin
            case (op)
                CBR_OP_PUSH: next_state.stack_pointer = push_addr;
                CBR_OP_POP:
                begin
                    next_state.pop_data = ram[state.stack_pointer];
                    next_state.stack_pointer = state.stack_pointer - 8'h01;
                end
                default: next_state.pop_data = state.pop_data;
            endcase
        end
        if (i_pc_load)
        begin
            next_state.program_counter = i_pc_target;
        end
        else if (i_instr_done)
        begin
            next_state.program_counter = state.program_counter +
                {14'h0000, i_instr_len};
        end
    end

    always_ff @(posedge i_mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state <= '0;
            state.program_counter <= CBR_PC_RESET;
            state.stack_pointer <= CBR_STACK_RESET;
            state.main_arith <= CBR_BYTE_RESET;
            state.status <= CBR_BYTE_RESET;
        end
        else if (i_ce)
        begin
            state <= next_state;
        end
    end

    assign o_main_arith = state.main_arith;
    assign o_second_operand = state.second_operand;
    assign o_program_counter = state.program_counter;
    assign o_data_pointer_addr = state.data_pointer_select ?
        state.data_pointer_1 : state.data_pointer_0;
    assign o_stack_pointer = state.stack_pointer;
    assign o_bank_select = bank;
    assign o_pop_data = state.pop_data;
    assign o_direct_rdata = state.direct_rdata;
    assign o_indirect_rdata = state.indirect_rdata;
    assign o_gr_rdata = state.gr_rdata;

    chk_push_sp_step: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_stack_op_valid && op == CBR_OP_PUSH && !i_direct_we)
        |=> state.stack_pointer == $past(state.stack_pointer) + 8'h01)
        else $error("Push did not increment stack pointer.");

    chk_push_ram_slot: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_stack_op_valid && op == CBR_OP_PUSH)
        |=> ram[state.stack_pointer] == $past(i_push_data))
        else $error("Pushed byte not at incremented address.");

    chk_pop_sp_step: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_stack_op_valid && op == CBR_OP_POP && !i_direct_we)
        |=> o_pop_data == $past(ram[state.stack_pointer])
            && state.stack_pointer == $past(state.stack_pointer) - 8'h01)
        else $error("Pop order or decrement wrong.");

    chk_pc_advance: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_instr_done && !i_pc_load)
        |=> o_program_counter == $past(o_program_counter) + {14'h0000, $past(i_instr_len)})
        else $error("Program counter did not advance by length.");

    chk_pc_hold: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (!i_instr_done && !i_pc_load) |=> $stable(o_program_counter))
        else $error("Program counter changed without cause.");

    chk_pc_jump: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_pc_load) |=> o_program_counter == $past(i_pc_target))
        else $error("Jump target not loaded.");

    chk_dp_select: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_direct_we && i_direct_addr == CBR_DP_SELECT_ADDR)
        |=> o_data_pointer_addr == ($past(i_direct_wdata[0]) ? $past(state.data_pointer_1)
            : $past(state.data_pointer_0)))
        else $error("Wrong data pointer presented.");

    chk_bank_map: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_gr_we && !(i_stack_op_valid && op == CBR_OP_PUSH))
        |=> ram[{3'b000, $past(bank), $past(i_gr_index)}] == $past(i_gr_wdata))
        else $error("Bank register write went to wrong address.");

    chk_acc_load: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_ce && i_acc_we && !i_muldiv_we) |=> o_main_arith == $past(i_acc_wdata))
        else $error("Accumulator did not take result.");

    chk_second_hold: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (!i_muldiv_we && !(i_direct_we && i_direct_addr == CBR_SECOND_OP_ADDR))
        |=> $stable(o_second_operand))
        else $error("Second operand changed outside multiply or divide.");

    // Checked at the write port because the upper RAM bytes start out unknown.
    chk_sfr_no_ram: assert property (@(posedge i_mclk) disable iff (!rst_sync)
        (i_direct_we && i_direct_addr >= CBR_SFR_BASE && !i_gr_we && !i_indirect_we
            && !(i_stack_op_valid && op == CBR_OP_PUSH))
        |-> !ram_we)
        else $error("Special register write reached RAM.");
endmodule

// [verif/cbr_core_regs_tb.sv]
// Self-checking testbench for the core basic register block.
`timescale 1ns/1ps
module cbr_core_regs_tb
    import cbr_pkg::*;
;
    logic i_mclk, i_reset_n, i_ce, i_direct_we, i_indirect_we, i_gr_we, i_acc_we;
    logic i_muldiv_we, i_stack_op_valid, i_instr_done, i_pc_load;
    logic [7:0] i_direct_addr, i_direct_wdata, i_indirect_addr, i_indirect_wdata, i_gr_wdata;
    logic [7:0] i_acc_wdata, i_muldiv_acc, i_muldiv_second, i_push_data;
    logic [2:0] i_gr_index, i_stack_op;
    logic [1:0] i_instr_len;
    logic [15:0] i_pc_target;
    logic [7:0] o_direct_rdata, o_indirect_rdata, o_gr_rdata, o_main_arith;
    logic [7:0] o_second_operand, o_pop_data, o_stack_pointer;
    logic [15:0] o_program_counter, o_data_pointer_addr, pc_exp;
    logic [1:0] o_bank_select;
    int err_count, num_checks;

    cbr_core_regs i_dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_direct_we(i_direct_we), .i_direct_addr(i_direct_addr),
        .i_direct_wdata(i_direct_wdata), .o_direct_rdata(o_direct_rdata),
        .i_indirect_we(i_indirect_we), .i_indirect_addr(i_indirect_addr),
        .i_indirect_wdata(i_indirect_wdata), .o_indirect_rdata(o_indirect_rdata),
        .i_gr_we(i_gr_we), .i_gr_index(i_gr_index), .i_gr_wdata(i_gr_wdata),
        .o_gr_rdata(o_gr_rdata), .i_acc_we(i_acc_we), .i_acc_wdata(i_acc_wdata),
        .o_main_arith(o_main_arith), .i_muldiv_we(i_muldiv_we),
        .i_muldiv_acc(i_muldiv_acc), .i_muldiv_second(i_muldiv_second),
        .o_second_operand(o_second_operand), .i_stack_op_valid(i_stack_op_valid),
        .i_stack_op(i_stack_op), .i_push_data(i_push_data), .o_pop_data(o_pop_data),
        .i_instr_done(i_instr_done), .i_instr_len(i_instr_len), .i_pc_load(i_pc_load),
        .i_pc_target(i_pc_target), .o_program_counter(o_program_counter),
        .o_data_pointer_addr(o_data_pointer_addr), .o_stack_pointer(o_stack_pointer),
        .o_bank_select(o_bank_select)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every drive lands 1 ns after the edge so no sampling race exists.
    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask

    task automatic do_reset();
        i_reset_n = 1'b0;
        repeat (8) tick();
        i_reset_n = 1'b1;
        repeat (3) tick();
    endtask

    task automatic wr_dir(input logic [7:0] a, input logic [7:0] d);
        i_direct_addr = a;
        i_direct_wdata = d;
        i_direct_we = 1'b1;
        tick();
        i_direct_we = 1'b0;
        tick();
    endtask

    // The extra edge lets the one-cycle registered read settle with a cycle to spare.
    task automatic rd_dir(input logic [7:0] a, input logic [7:0] exp);
        i_direct_addr = a;
        tick();
        tick();
        chk("direct read", {8'h00, o_direct_rdata}, {8'h00, exp});
    endtask

    task automatic rd_ind(input logic [7:0] a, input logic [7:0] exp);
        i_indirect_addr = a;
        tick();
        tick();
        chk("indirect read", {8'h00, o_indirect_rdata}, {8'h00, exp});
    endtask

    task automatic stack_op(input logic [2:0] op, input logic [7:0] d);
        i_stack_op = op;
        i_push_data = d;
        i_stack_op_valid = 1'b1;
        tick();
        i_stack_op_valid = 1'b0;
        tick();
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_count++;
        report_and_stop();
    end

    initial
    begin
        {i_direct_we, i_indirect_we, i_gr_we, i_acc_we, i_muldiv_we} = 5'h00;
        {i_stack_op_valid, i_instr_done, i_pc_load} = 3'h0;
        {i_direct_addr, i_direct_wdata, i_indirect_addr, i_indirect_wdata} = 32'h0;
        {i_gr_wdata, i_acc_wdata, i_muldiv_acc, i_muldiv_second, i_push_data} = 40'h0;
        {i_gr_index, i_stack_op, i_instr_len, i_pc_target} = 24'h0;
        i_ce = 1'b1;
        do_reset();
        chk("pc reset", o_program_counter, 16'h0000);
        chk("stack reset", {8'h00, o_stack_pointer}, 16'h0007);
        chk("acc reset", {8'h00, o_main_arith}, 16'h0000);
        chk("bank reset", {14'h0, o_bank_select}, 16'h0000);
        chk("dp reset", o_data_pointer_addr, 16'h0000);
        stack_op(3'h1, 8'h3C);
        chk("push ptr", {8'h00, o_stack_pointer}, 16'h0008);
        rd_ind(8'h08, 8'h3C);
        stack_op(3'h1, 8'hA5);
        stack_op(3'h2, 8'h00);
        chk("pop data", {8'h00, o_pop_data}, 16'h00A5);
        chk("pop ptr", {8'h00, o_stack_pointer}, 16'h0008);
        stack_op(3'h2, 8'h00);
        chk("pop data", {8'h00, o_pop_data}, 16'h003C);
        wr_dir(CBR_STACK_PTR_ADDR, 8'h40);
        stack_op(3'h1, 8'h11);
        rd_ind(8'h41, 8'h11);
        for (int b = 0; b < 4; b++)
        begin
            wr_dir(CBR_STATUS_ADDR, 8'(b << CBR_BANK_SEL_LSB));
            chk("bank select", {14'h0, o_bank_select}, 16'(b));
            i_gr_index = 3'h4;
            i_gr_wdata = 8'(8'h50 + b);
            i_gr_we = 1'b1;
            tick();
            i_gr_we = 1'b0;
            rd_dir(8'(b * 8 + 4), 8'(8'h50 + b));
            wr_dir(8'(b * 8 + 7), 8'(8'h60 + b));
            i_gr_index = 3'h7;
            tick();
            tick();
            chk("bank reg", {8'h00, o_gr_rdata}, 16'(8'h60 + b));
        end
        wr_dir(CBR_STATUS_ADDR, 8'h00);
        // Accumulator and operand register, with both writers colliding before a direct operand write.
        i_acc_wdata = 8'h1E;
        i_acc_we = 1'b1;
        tick();
        i_acc_we = 1'b0;
        tick();
        chk("acc", {8'h00, o_main_arith}, 16'h001E);
        rd_dir(CBR_MAIN_ARITH_ADDR, 8'h1E);
        // Clock enable low must freeze the accumulator and the stack pointer.
        {i_ce, i_acc_we, i_acc_wdata} = {2'b01, 8'h5B};
        stack_op(3'h1, 8'hEE);
        {i_ce, i_acc_we} = 2'b10;
        chk("ce acc hold", {8'h00, o_main_arith}, 16'h001E);
        chk("ce stack hold", {8'h00, o_stack_pointer}, 16'h0041);
        stack_op(3'h3, 8'h00);
        chk("no-op stack", {8'h00, o_stack_pointer}, 16'h0041);
        {i_muldiv_acc, i_muldiv_second} = 16'h2D07;
        {i_acc_we, i_muldiv_we} = 2'b11;
        tick();
        {i_acc_we, i_muldiv_we} = 2'b00;
        tick();
        chk("muldiv acc", {8'h00, o_main_arith}, 16'h002D);
        chk("muldiv second", {8'h00, o_second_operand}, 16'h0007);
        wr_dir(CBR_SECOND_OP_ADDR, 8'h99);
        chk("second store", {8'h00, o_second_operand}, 16'h0099);
        pc_exp = 16'h0000;
        for (int n = 1; n < 4; n++)
        begin
            i_instr_len = 2'(n);
            i_instr_done = 1'b1;
            tick();
            i_instr_done = 1'b0;
            tick();
            pc_exp = pc_exp + 16'(n);
            chk("pc step", o_program_counter, pc_exp);
        end
        {i_pc_load, i_instr_done, i_pc_target} = {2'b11, 16'h2430};
        tick();
        {i_pc_load, i_instr_done} = 2'b00;
        tick();
        chk("pc jump", o_program_counter, 16'h2430);
        wr_dir(8'h90, 8'hFF);
        chk("pc untouched", o_program_counter, 16'h2430);
        rd_dir(8'h90, 8'h00);
        {i_indirect_addr, i_indirect_wdata, i_indirect_we} = {16'h905A, 1'b1};
        tick();
        i_indirect_we = 1'b0;
        rd_ind(8'h90, 8'h5A);
        rd_dir(8'h90, 8'h00);
        wr_dir(8'h7F, 8'h77);
        rd_ind(8'h7F, 8'h77);
        wr_dir(CBR_DP0_LO_ADDR, 8'h34);
        wr_dir(CBR_DP0_HI_ADDR, 8'h12);
        wr_dir(CBR_DP1_LO_ADDR, 8'hCD);
        wr_dir(CBR_DP1_HI_ADDR, 8'hAB);
        chk("dp0 address", o_data_pointer_addr, 16'h1234);
        wr_dir(CBR_DP_SELECT_ADDR, 8'h01);
        chk("dp1 address", o_data_pointer_addr, 16'hABCD);
        rd_dir(CBR_DP1_HI_ADDR, 8'hAB);
        wr_dir(CBR_DP_SELECT_ADDR, 8'h00);
        chk("dp0 again", o_data_pointer_addr, 16'h1234);
        stack_op(3'h1, 8'h22);
        do_reset();
        chk("stack rereset", {8'h00, o_stack_pointer}, 16'h0007);
        chk("pc rereset", o_program_counter, 16'h0000);
        report_and_stop();
    end
endmodule
